// ==== dv/rcp_clock_ctrl_asserts.sv ====
// Port-level checker for the reference clock control block.
// Assumes one pclk domain; bound to the top module below.
`timescale 1ns/1ps
module rcp_clock_ctrl_asserts import rcp_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and controls.
  input wire logic crystal_select_pin,
  input wire logic pll_lock_raw,
  input wire logic lock_indicator_pin,
  input wire logic multiplier_select,
  input wire logic input_divider_enable,
  input wire logic [6:0] multiply_factor,
  input wire logic [2:0] oscillator_range_select,
  input wire logic [2:0] pump_current_select,
  input wire logic crystal_oscillator_enable,
  input wire logic [1:0] reference_replica_drive,
  input wire logic reference_replica_output_oe
);
  // ************************************************
  // Write capture
  // ************************************************
  logic wr_d, wr_q; // A full-word write to control three completed.
  logic [31:0] wd_d, wd_q; // Data of that write.
  logic [6:0] fx; // Factor expected after the floor is applied.
  logic mx; // Multiplied path expected.
  // Only full-word writes are tracked, so partial lanes never mislead the checks.
  always_comb begin
    wr_d = psel && penable && pready && pwrite && paddr[7:0] == RCP_OFS_CTRL3 && pstrb == 4'hf;
    wd_d = wr_d ? pwdata : wd_q;
    fx = (wd_q[7:1] < RCP_MULT_MIN) ? RCP_MULT_MIN : wd_q[7:1];
    mx = wd_q[8] && (wd_q[26:24] <= RCP_RANGE_LAST);
  end
  // Registers the capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 1'b0;
      wd_q <= 32'h0;
    end else begin
      wr_q <= wr_d;
      wd_q <= wd_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************************************************
  // Properties
  // ************************************************
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  wait_state_a: assert property (psel && penable && !pready && $past(psel && !penable) |=> pready)
    else $error("pready not in second access cycle");
  err_map_a: assert property (pready |-> pslverr == !(paddr[7:0] == 8'h00 || paddr[7:0] == 8'h04))
    else $error("pslverr does not follow the map");
  factor_apply_a: assert property (wr_q |-> ##[1:3] multiply_factor == fx)
    else $error("factor not applied");
  range_apply_a: assert property (wr_q |-> ##[1:3] (oscillator_range_select == wd_q[26:24] && multiplier_select == mx))
    else $error("range or path not applied");
  pump_apply_a: assert property (wr_q |-> ##[1:3] (pump_current_select == wd_q[21:19] && input_divider_enable == wd_q[15]))
    else $error("pump or divider not applied");
  range_bypass_a: assert property (multiplier_select |-> oscillator_range_select <= RCP_RANGE_LAST)
    else $error("multiplier used with bypass code");
  factor_floor_a: assert property (multiply_factor >= RCP_MULT_MIN) else $error("factor below floor");
  lock_low_a: assert property (!multiplier_select && $past(!multiplier_select) |-> !lock_indicator_pin)
    else $error("lock high while bypassed");
  lock_rise_a: assert property ((multiplier_select && pll_lock_raw) [*8] |->
    ##[0:30] (lock_indicator_pin || !pll_lock_raw || !multiplier_select))
    else $error("lock never rose");
  replica_on_a: assert property (reference_replica_output_oe |-> multiplier_select && reference_replica_drive != RCP_DRIVE_OFF)
    else $error("replica driven wrongly");
  replica_off_a: assert property (!multiplier_select |-> !reference_replica_output_oe && reference_replica_drive == RCP_DRIVE_OFF)
    else $error("replica driven while bypassed");
  xtal_off_a: assert property (!crystal_select_pin [*5] |=> !crystal_oscillator_enable)
    else $error("crystal on with pin low");
  cover property (pready && pslverr);
  cover property ($rose(lock_indicator_pin));
  cover property (reference_replica_output_oe && reference_replica_drive == RCP_DRIVE_HIGH);
endmodule : rcp_clock_ctrl_asserts
bind rcp_clock_ctrl rcp_clock_ctrl_asserts rcp_clock_ctrl_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .crystal_select_pin(crystal_select_pin),
  .pll_lock_raw(pll_lock_raw), .lock_indicator_pin(lock_indicator_pin),
  .multiplier_select(multiplier_select), .input_divider_enable(input_divider_enable),
  .multiply_factor(multiply_factor), .oscillator_range_select(oscillator_range_select),
  .pump_current_select(pump_current_select), .crystal_oscillator_enable(crystal_oscillator_enable),
  .reference_replica_drive(reference_replica_drive),
  .reference_replica_output_oe(reference_replica_output_oe));

// ==== dv/rcp_clock_ctrl_test.sv ====
// Self-checking bench for the reference clock control block over APB.
// Assumes the reference model stands in for the analog loop and oscillator.
`timescale 1ns/1ps
module rcp_clock_ctrl_test;
  import rcp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, xpin, lock_raw, lock;
  logic [31:0] paddr, pwdata, prdata, exp_c3, rd;
  logic [3:0] pstrb;
  logic msel, div_en, xosc, oe, er;
  logic [6:0] fact;
  logic [2:0] range, pump;
  logic [1:0] drive;
  int errors, n_compared;
  rcp_clock_ctrl #(.LOCK_DWELL_CYCLES(2)) rcp_clock_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_select_pin(xpin), .pll_lock_raw(lock_raw), .lock_indicator_pin(lock),
    .multiplier_select(msel), .input_divider_enable(div_en), .multiply_factor(fact),
    .oscillator_range_select(range), .pump_current_select(pump), .crystal_oscillator_enable(xosc),
    .reference_replica_drive(drive), .reference_replica_output_oe(oe));
  rcp_ref_model rcp_ref_model_inst (.pclk(pclk), .presetn(presetn), .multiplier_select(msel),
    .multiply_factor(fact), .oscillator_range_select(range), .slow(slow), .pll_lock_raw(lock_raw));
  // ************************************************
  // Helpers
  // ************************************************
  // Control three after a write, with lane strobes, storage mask and factor floor.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) r[8*i+:8] = s[i] ? d[8*i+:8] : o[8*i+:8];
    r = r & RCP_CTRL3_MASK;
    if (s[0] && r[7:1] < RCP_MULT_MIN) r[7:1] = RCP_MULT_MIN;
    return r;
  endfunction : merge
  // Nominal pump current; the step is not quite even at the top.
  function automatic logic [8:0] pump_ua(input logic [2:0] c);
    return (c == 3'h7) ? 9'h183 : (c == 3'h6) ? 9'h16b : 9'h0d4 + 9'h019 * c;
  endfunction : pump_ua
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // One APB transfer; waits for pready under a bounded count.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) check("pready", 32'h1, 32'h0);
    if (w && a == RCP_OFS_CTRL3 && er === 1'b0) exp_c3 = merge(exp_c3, d, s);
  endtask : apb
  // Compares every control output but the crystal enable, control three and the status pump field with the model of control three.
  task automatic check_outs;
    logic mx;
    repeat (3) @(posedge pclk);
    mx = exp_c3[8] && exp_c3[26:24] <= RCP_RANGE_LAST;
    check("mult_sel", 32'(mx), 32'(msel));
    check("factor", 32'(exp_c3[7:1]), 32'(fact));
    check("range", 32'(exp_c3[26:24]), 32'(range));
    check("pump", 32'(exp_c3[21:19]), 32'(pump));
    check("divider", 32'(exp_c3[15]), 32'(div_en));
    check("drive", mx ? 32'(exp_c3[31:30]) : 32'h0, 32'(drive));
    check("replica_oe", 32'(mx && exp_c3[31:30] != 2'h0), 32'(oe));
    apb(1'b0, RCP_OFS_CTRL3, 32'h0, 4'hf);
    check("ctrl3", exp_c3, rd);
    apb(1'b0, RCP_OFS_STATUS, 32'h0, 4'hf);
    check("pump_ua", 32'(pump_ua(exp_c3[21:19])), 32'(rd[24:16]));
  endtask : check_outs
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ************************************************
  // Clock, watchdog and sequence
  // ************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end
  initial begin
    int n;
    logic [31:0] fv [4];
    fv = '{32'h0000_0116, 32'h0000_01fe, 32'h0000_0118, 32'h0000_010c};
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
    pstrb = 4'h0; xpin = 1'b0; slow = 1'b0; errors = 0; n_compared = 0;
    exp_c3 = RCP_CTRL3_RESET;
    void'($urandom(69));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_outs();
    // Every drive, range and pump code with the multiplier enabled.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, RCP_OFS_CTRL3, (32'(i % 4) << 30) | (32'(i) << 24) | (32'(i) << 19) | 32'h128, 4'hf);
      check_outs();
    end
    // Factor boundaries and below-floor values, then a single-lane write.
    foreach (fv[i]) begin
      apb(1'b1, RCP_OFS_CTRL3, fv[i], 4'hf);
      check_outs();
    end
    apb(1'b1, RCP_OFS_CTRL3, 32'hffff_ffff, 4'h2);
    check_outs();
    repeat (16) begin
      apb(1'b1, RCP_OFS_CTRL3, $urandom, 4'($urandom));
      check_outs();
    end
    // Unmapped places answer with an error; status ignores writes.
    apb(1'b0, 8'h08, 32'h0, 4'hf);
    check("err_rd", 32'h1, 32'(er));
    apb(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
    check("err_wr", 32'h1, 32'(er));
    apb(1'b1, RCP_OFS_STATUS, 32'hffff_ffff, 4'hf);
    check("err_st", 32'h0, 32'(er));
    check_outs();
    // Lock with a prompt and a slow loop, then bypass by range code.
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      apb(1'b1, RCP_OFS_CTRL3, 32'h0200_0128, 4'hf);
      n = 0;
      while (lock !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
      check("lock", 32'h1, 32'(lock));
      apb(1'b1, RCP_OFS_CTRL3, 32'h0600_0128, 4'hf);
      repeat (8) @(posedge pclk);
      check("lock_byp", 32'h0, 32'(lock));
    end
    // Crystal oscillator needs both the pin and the register bit.
    xpin <= 1'b1;
    apb(1'b1, RCP_OFS_CTRL3, 32'h0701_0018, 4'hf);
    repeat (8) @(posedge pclk);
    check("xtal_on", 32'h1, 32'(xosc));
    xpin <= 1'b0;
    repeat (8) @(posedge pclk);
    check("xtal_pin", 32'h0, 32'(xosc));
    xpin <= 1'b1;
    apb(1'b1, RCP_OFS_CTRL3, 32'h0700_0018, 4'hf);
    repeat (8) @(posedge pclk);
    check("xtal_bit", 32'h0, 32'(xosc));
    print_verdict();
  end
endmodule : rcp_clock_ctrl_test

// ==== dv/rcp_ref_model.sv ====
// Behavioural reference source and analog multiplier standing beyond the block.
// Assumes the block's registered controls; reports a raw lock level back.
`timescale 1ns/1ps
module rcp_ref_model import rcp_pkg::*; #(
  parameter int REF_MHZ = 25 // Reference rate, well under the 1 GHz divider limit.
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Controls from the block.
  input wire logic multiplier_select,
  input wire logic [6:0] multiply_factor,
  input wire logic [2:0] oscillator_range_select,
  input wire logic slow,
  // Raw lock flag.
  output logic pll_lock_raw
);
  // ************************************************
  // Settling counter
  // ************************************************
  logic [6:0] cnt_d, cnt_q; // Cycles of stable, in-band multiplied configuration.
  logic [9:0] cfg_d, cfg_q; // Configuration seen last cycle.
  logic band; // Multiplied rate inside the oscillator band.
  // Any change of factor or range restarts settling, as a real loop would.
  always_comb begin
    band = (REF_MHZ * multiply_factor >= 420) && (REF_MHZ * multiply_factor <= 1000);
    cfg_d = {multiply_factor, oscillator_range_select};
    if (!multiplier_select || !band || cfg_d != cfg_q) begin
      cnt_d = 7'h00;
    end else if (cnt_q != 7'h7f) begin
      cnt_d = cnt_q + 7'h01;
    end else begin
      cnt_d = cnt_q;
    end
  end
  // Registers the counter and configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
      cfg_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
      cfg_q <= cfg_d;
    end
  end
  // A slow loop takes much longer to settle, so the qualifier must wait it out.
  assign pll_lock_raw = (cnt_q >= (slow ? 7'h30 : 7'h04));
endmodule : rcp_ref_model

// ==== verilog/rcp_clock_ctrl.sv ====
// Reference clock path and multiplier configuration, with its APB register file.
// Assumes the analog multiplier, oscillator and buffers sit outside and take
// the registered control outputs; the lock flag and crystal pin are asynchronous.
//
// Summary of operation
// - One enable bit picks multiplied or direct clock.
// - Replica output copies reference while multiplier runs.
// - Replica drive code: tristate, low, medium, high.
// - Crystal mode from pin plus register bit.
// - Multiplication factor programmable from 12 to 127.
// - Range codes 0 to 5; 6 and 7 bypass.
// - Pump code selects 212 to 387 microamps.
// - Lock pin high when locked, low bypassed.
`timescale 1ns/1ps
module rcp_clock_ctrl import rcp_pkg::*; #(
  parameter int LOCK_DWELL_CYCLES = 16 // Stable lock cycles before the pin rises.
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and analog flags.
  input wire logic crystal_select_pin,
  input wire logic pll_lock_raw,
  output logic lock_indicator_pin,
  // Controls to the analog clock path.
  output logic multiplier_select,
  output logic input_divider_enable,
  output logic [6:0] multiply_factor,
  output logic [2:0] oscillator_range_select,
  output logic [2:0] pump_current_select,
  output logic crystal_oscillator_enable,
  output logic [1:0] reference_replica_drive,
  output logic reference_replica_output_oe
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [31:0] ctrl3_q; // Control register three storage.
  logic [31:0] ctrl3_d;
  logic [31:0] prdata_q; // Read data held for the access phase.
  logic [31:0] prdata_d;
  logic pready_q; // One wait state, then ready.
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [2:0] xpin_sync_q; // Crystal-select pin synchroniser.
  logic [2:0] xpin_sync_d;
  logic xpin_q; // Accepted crystal-select level.
  logic xpin_d;
  logic mult_sel_q; // Multiplied path in use.
  logic mult_sel_d;
  logic div_en_q;
  logic div_en_d;
  logic [6:0] factor_q;
  logic [6:0] factor_d;
  logic [2:0] range_q;
  logic [2:0] range_d;
  logic [2:0] pump_q;
  logic [2:0] pump_d;
  logic xtal_en_q;
  logic xtal_en_d;
  logic [1:0] drive_q;
  logic [1:0] drive_d;
  logic drive_oe_q;
  logic drive_oe_d;
  logic lock_pin_q;
  logic lock_pin_d;
  logic [8:0] pump_ua_q; // Nominal pump current shown in status.
  logic [8:0] pump_ua_d;
  logic locked; // Qualified lock from the filter.
  logic relock; // Multiplier settings changed; lock must be earned again.
  logic access; // Access phase of a transfer.
  logic done; // Edge at which the transfer completes.
  logic addr_ok; // Address maps to a register.
  logic [31:0] wmask; // Byte lanes written.
  logic [31:0] status;
  logic [6:0] wr_factor; // Factor field of the write data.

  // ***************************************************************
  // APB slave
  // ***************************************************************
  assign access = psel && penable;
  assign done = access && pready_q;
  assign addr_ok = (paddr[RCP_ADDR_W-1:0] == RCP_OFS_CTRL3) ||
                   (paddr[RCP_ADDR_W-1:0] == RCP_OFS_STATUS);
  assign wr_factor = pwdata[RCP_MULT_HI:RCP_MULT_LO];

  // Expand the byte strobes into a bit mask.
  always_comb begin
    wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // Status word assembled from live block state.
  always_comb begin
    status = 32'h0000_0000;
    status[RCP_ST_LOCK_BIT] = lock_pin_q;
    status[RCP_ST_MULT_BIT] = mult_sel_q;
    status[RCP_ST_XPIN_BIT] = xpin_q;
    status[RCP_ST_XTAL_BIT] = xtal_en_q;
    status[RCP_ST_FACT_LO +: 7] = factor_q;
    status[RCP_ST_PUMP_LO +: 9] = pump_ua_q;
  end

  // Handshake, read data and error answer.  Ready comes one cycle into the
  // access phase so that read data can stand in a flip-flop when sampled.
  always_comb begin
    pready_d = access && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (access && !pready_q) begin
      pslverr_d = !addr_ok;
      prdata_d = 32'h0000_0000;
      if (!pwrite && paddr[RCP_ADDR_W-1:0] == RCP_OFS_CTRL3) begin
        prdata_d = ctrl3_q;
      end else if (!pwrite && paddr[RCP_ADDR_W-1:0] == RCP_OFS_STATUS) begin
        prdata_d = status;
      end
    end
  end

  // Register write.  A factor below the least legal value is raised to it,
  // since the multiplier cannot run below that ratio.
  always_comb begin
    ctrl3_d = ctrl3_q;
    if (done && pwrite && paddr[RCP_ADDR_W-1:0] == RCP_OFS_CTRL3) begin
      ctrl3_d = ((ctrl3_q & ~wmask) | (pwdata & wmask)) & RCP_CTRL3_MASK;
      if (pstrb[0] && wr_factor < RCP_MULT_MIN) begin
        ctrl3_d[RCP_MULT_HI:RCP_MULT_LO] = RCP_MULT_MIN;
      end
    end
  end

  // ***************************************************************
  // Crystal-select pin
  // ***************************************************************
  // Three stages; a change counts once the second and third agree.
  always_comb begin
    xpin_sync_d = {xpin_sync_q[1:0], crystal_select_pin};
    xpin_d = xpin_q;
    if (xpin_sync_q[1] == xpin_sync_q[2]) begin
      xpin_d = xpin_sync_q[2];
    end
  end

  // ***************************************************************
  // Clock path controls
  // ***************************************************************
  // The multiplier runs only if enabled and the range code is not a bypass
  // code; otherwise the direct path, after the optional divider, is used.
  always_comb begin
    mult_sel_d = ctrl3_q[RCP_PLL_EN_BIT] &&
                 !rcp_range_bypass(ctrl3_q[RCP_RANGE_HI:RCP_RANGE_LO]);
    div_en_d = ctrl3_q[RCP_DIV_EN_BIT];
    factor_d = ctrl3_q[RCP_MULT_HI:RCP_MULT_LO];
    range_d = ctrl3_q[RCP_RANGE_HI:RCP_RANGE_LO];
    pump_d = ctrl3_q[RCP_PUMP_HI:RCP_PUMP_LO];
    pump_ua_d = RCP_PUMP_UA[ctrl3_q[RCP_PUMP_HI:RCP_PUMP_LO]];
    xtal_en_d = xpin_q && ctrl3_q[RCP_XTAL_EN_BIT];
  end

  // Replica buffer: driven only while the multiplier runs and the code is
  // not tristate.  The drive code is held at off whenever the pin floats.
  always_comb begin
    drive_d = RCP_DRIVE_OFF;
    drive_oe_d = 1'b0;
    if (mult_sel_d) begin
      unique case (rcp_drive_t'(ctrl3_q[RCP_REPLICA_HI:RCP_REPLICA_LO]))
        RCP_DRV_OFF: begin
          drive_d = RCP_DRIVE_OFF;
        end
        RCP_DRV_LOW: begin
          drive_d = RCP_DRIVE_LOW;
          drive_oe_d = 1'b1;
        end
        RCP_DRV_MED: begin
          drive_d = RCP_DRIVE_MED;
          drive_oe_d = 1'b1;
        end
        RCP_DRV_HIGH: begin
          drive_d = RCP_DRIVE_HIGH;
          drive_oe_d = 1'b1;
        end
      endcase
    end
  end

  // ***************************************************************
  // Lock indication
  // ***************************************************************
  // Any change of path, factor or range restarts the lock qualifier; the pin falls together
  // with a path change, but only one cycle after a new factor or range reaches the outputs.
  assign relock = (mult_sel_d != mult_sel_q) || (factor_d != factor_q) ||
                  (range_d != range_q) || !mult_sel_q;

  rcp_lock_filter #(
    .DWELL_CYCLES(LOCK_DWELL_CYCLES)
  ) u_lock_filter (
    .pclk(pclk),
    .presetn(presetn),
    .lock_raw(pll_lock_raw),
    .restart(relock),
    .locked(locked)
  );

  // Lock pin is low whenever the multiplier is bypassed.
  always_comb begin
    lock_pin_d = mult_sel_q && mult_sel_d && locked;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // All state of the block but the lock filter's; reset leaves the multiplier bypassed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl3_q <= RCP_CTRL3_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      xpin_sync_q <= 3'h0;
      xpin_q <= 1'b0;
      mult_sel_q <= 1'b0;
      div_en_q <= 1'b0;
      factor_q <= RCP_MULT_MIN;
      range_q <= 3'h7;
      pump_q <= 3'h0;
      pump_ua_q <= 9'h0d4;
      xtal_en_q <= 1'b0;
      drive_q <= RCP_DRIVE_OFF;
      drive_oe_q <= 1'b0;
      lock_pin_q <= 1'b0;
    end else begin
      ctrl3_q <= ctrl3_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      xpin_sync_q <= xpin_sync_d;
      xpin_q <= xpin_d;
      mult_sel_q <= mult_sel_d;
      div_en_q <= div_en_d;
      factor_q <= factor_d;
      range_q <= range_d;
      pump_q <= pump_d;
      pump_ua_q <= pump_ua_d;
      xtal_en_q <= xtal_en_d;
      drive_q <= drive_d;
      drive_oe_q <= drive_oe_d;
      lock_pin_q <= lock_pin_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Every output stands straight from a flip-flop.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lock_indicator_pin = lock_pin_q;
  assign multiplier_select = mult_sel_q;
  assign input_divider_enable = div_en_q;
  assign multiply_factor = factor_q;
  assign oscillator_range_select = range_q;
  assign pump_current_select = pump_q;
  assign crystal_oscillator_enable = xtal_en_q;
  assign reference_replica_drive = drive_q;
  assign reference_replica_output_oe = drive_oe_q;

endmodule : rcp_clock_ctrl

// ==== verilog/rcp_lock_filter.sv ====
// Lock qualifier for the raw phase-lock flag of the analog multiplier.
// Assumes the raw flag is asynchronous to pclk and may chatter while settling.
`timescale 1ns/1ps
module rcp_lock_filter import rcp_pkg::*; #(
  parameter int DWELL_CYCLES = 16 // Stable cycles before lock is reported.
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw lock flag and restart request.
  input wire logic lock_raw,
  input wire logic restart,
  // Qualified lock level.
  output logic locked
);

  // ***************************************************************
  // Synchroniser
  // ***************************************************************
  logic [2:0] sync_q; // Three stages; only stages two and three are compared.
  logic [2:0] sync_d;
  logic level_q; // Accepted level of the raw flag.
  logic level_d;
  logic [15:0] count_q; // Dwell counter.
  logic [15:0] count_d;
  logic locked_q;
  logic locked_d;

  // Shift the raw flag in and accept a change once the last two stages agree.
  always_comb begin
    sync_d = {sync_q[1:0], lock_raw};
    level_d = level_q;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
  end

  // ***************************************************************
  // Dwell counter
  // ***************************************************************
  // A lock is reported only after the flag has stayed high for the dwell time,
  // so a flag that flickers during acquisition never reaches the pin.
  always_comb begin
    count_d = count_q;
    locked_d = locked_q;
    if (restart || !level_q) begin
      count_d = 16'h0000;
      locked_d = 1'b0;
    end else if (count_q >= 16'(DWELL_CYCLES - 1)) begin
      locked_d = 1'b1;
    end else begin
      count_d = count_q + 16'h0001;
    end
  end

  // Registers of the synchroniser and the counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
      count_q <= 16'h0000;
      locked_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      level_q <= level_d;
      count_q <= count_d;
      locked_q <= locked_d;
    end
  end

  assign locked = locked_q;

endmodule : rcp_lock_filter

// ==== verilog/rcp_pkg.sv ====
// Package for the reference clock and multiplier configuration block.
// Holds register offsets, field positions, reset values and the pump current table.
// Assumes a 32-bit APB register bus and a single 200 MHz pclk domain.
package rcp_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] RCP_OFS_CTRL3 = 8'h00; // Control register three.
  localparam logic [7:0] RCP_OFS_STATUS = 8'h04; // Read-only block status.
  localparam int RCP_ADDR_W = 8; // Decoded address bits.

  // ***************************************************************
  // Control register three fields
  // ***************************************************************
  localparam int RCP_REPLICA_HI = 31; // Replica buffer drive code.
  localparam int RCP_REPLICA_LO = 30;
  localparam int RCP_RANGE_HI = 26; // Oscillator range code.
  localparam int RCP_RANGE_LO = 24;
  localparam int RCP_PUMP_HI = 21; // Pump current code.
  localparam int RCP_PUMP_LO = 19;
  localparam int RCP_XTAL_EN_BIT = 16; // Crystal oscillator allowed.
  localparam int RCP_DIV_EN_BIT = 15; // Input divider enable.
  localparam int RCP_PLL_EN_BIT = 8; // Multiplier path enable.
  localparam int RCP_MULT_HI = 7; // Multiplication factor.
  localparam int RCP_MULT_LO = 1;

  // Bits of control register three that hold storage; the rest read as zero.
  localparam logic [31:0] RCP_CTRL3_MASK = 32'hc739_81fe;
  // After reset: multiplier off, range bypassed, factor at its least value.
  localparam logic [31:0] RCP_CTRL3_RESET = 32'h0700_0018;

  // ***************************************************************
  // Status register fields
  // ***************************************************************
  localparam int RCP_ST_LOCK_BIT = 0; // Lock indicator as driven.
  localparam int RCP_ST_MULT_BIT = 1; // Multiplied path in use.
  localparam int RCP_ST_XPIN_BIT = 2; // Synchronised crystal-select pin.
  localparam int RCP_ST_XTAL_BIT = 3; // Crystal oscillator running.
  localparam int RCP_ST_FACT_LO = 8; // Effective factor, 7 bits.
  localparam int RCP_ST_PUMP_LO = 16; // Nominal pump current, 9 bits.

  // ***************************************************************
  // Codes and limits
  // ***************************************************************
  localparam logic [1:0] RCP_DRIVE_OFF = 2'h0; // Replica tristate.
  localparam logic [1:0] RCP_DRIVE_LOW = 2'h1;
  localparam logic [1:0] RCP_DRIVE_MED = 2'h2;
  localparam logic [1:0] RCP_DRIVE_HIGH = 2'h3;
  localparam logic [2:0] RCP_RANGE_LAST = 3'h5; // Codes above bypass.
  localparam logic [6:0] RCP_MULT_MIN = 7'h0c; // Least factor, 12.
  localparam logic [6:0] RCP_MULT_MAX = 7'h7f; // Greatest factor, 127.

  // Nominal pump current in microamps for each code.
  localparam logic [8:0] RCP_PUMP_UA [8] = '{9'h0d4, 9'h0ed, 9'h106, 9'h11f,
                                            9'h138, 9'h151, 9'h16b, 9'h183};

  // Drive codes for the replica buffer.
  typedef enum logic [1:0] {
    RCP_DRV_OFF = 2'b00,
    RCP_DRV_LOW = 2'b01,
    RCP_DRV_MED = 2'b10,
    RCP_DRV_HIGH = 2'b11
  } rcp_drive_t;

  // True when an oscillator range code bypasses the multiplier.
  function automatic logic rcp_range_bypass(input logic [2:0] code);
    rcp_range_bypass = (code > RCP_RANGE_LAST);
  endfunction : rcp_range_bypass

endpackage : rcp_pkg
